//--- hdl/lhi_host_if.sv
// Host interface of the character display controller: parallel, SPI, I2C.
// Assumes all pins are asynchronous to mclk_i; serial clocks are sampled.
// Function
// [R1] Narrow mode: two transfers on upper lines
// [R2] Upper nibble first, lower nibble second
// [R3] Busy rises only after second nibble
// [R4] Wide mode: one transfer, eight lines
// [R5] Two straps choose parallel, I2C or SPI
// [R6] Host drives strobe, select, direction lines
// [R7] SPI uses chip select, data, clock pins
// [R8] SPI bits captured on rising clock
// [R9] Host ties select low, sets wide width
// [R10] SDA change during SCL high is control
// [R11] START falls, STOP rises, SCL high
// [R12] Master starts only on idle bus
// [R13] Acknowledge every received byte, ninth clock
// [R14] Reader withholds last ack; no drive
// [R15] Four addresses, low bits from straps
// [R16] Unmatched address: no ack, no action
// [R17] Control/data pairs until follow flag clear
// [R18] RAM flag routes data bytes to RAM
// [R19] I2C supports writes only
// [R20] Flag clear: bytes are instructions
// [R21] Data byte advances RAM pointer
// [R22] Width bit clear selects 4-bit transfers
// [R23] Status read returns busy on top bit
// [R24] SPI ignores clocks while deselected
// [R25] SPI MSB first, select sampled last bit
`timescale 1ns/1ps
module lhi_host_if
	import lhi_pkg::*;
(
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	input  wire logic       bus_select_strap_upper_i,
	input  wire logic       bus_select_strap_lower_i,
	input  wire logic       width_select_bit_i,
	input  wire logic       par_en_i,
	input  wire logic       reg_select_line_i,
	input  wire logic       par_rw_i,
	input  wire logic [7:0] db_i,
	input  wire logic [6:0] addr_counter_i,
	output logic      [7:0] db_o,
	output logic      [7:0] db_oe_n_o,
	output logic            byte_valid_o,
	output logic            byte_is_data_o,
	output logic      [7:0] byte_value_o,
	output logic      [6:0] ram_ptr_o,
	output logic            busy_indicator_o
);
	// ==========================================================
	// Pin synchronisation
	lhi_par_s par_raw;
	lhi_par_s par;
	logic [1:0] strap;

	assign par_raw = '{en: par_en_i, rs: reg_select_line_i, rw: par_rw_i, db: db_i};

	lhi_sync #(.W(13)) u_sync (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.async_i  ({bus_select_strap_upper_i, bus_select_strap_lower_i, par_raw}),
		.sync_o   ({strap, par})
	);

	// Straps are caught once the synchroniser has filled after reset release;
	// an earlier capture would see the flops' reset zeros, not the pins
	lhi_port_e  port_reg;
	logic       strap_done_reg;
	logic [1:0] strap_age_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			port_reg       <= LHI_PORT_PAR;
			strap_done_reg <= 1'b0;
			strap_age_reg  <= 2'h0;
		end else if (!strap_done_reg) begin
			strap_age_reg <= strap_age_reg + 2'h1;
			if (strap_age_reg == 2'h2) begin
				port_reg       <= lhi_port_e'(strap); // [R5]
				strap_done_reg <= 1'b1;
			end
		end
	end

	// Serial pins share the upper data lines
	logic cs_n;
	logic spi_si;
	logic spi_ck;
	logic sda;
	logic scl;
	logic [1:0] addr_strap;

	assign cs_n       = par.db[5]; // [R7]
	assign spi_si     = par.db[7];
	assign spi_ck     = par.db[6];
	assign sda        = par.db[6];
	assign scl        = par.db[7];
	assign addr_strap = par.db[1:0]; // [R15]

	// Previous samples for edge detection
	logic en_d_reg;
	logic cs_d_reg;
	logic ck_d_reg;
	logic sda_d_reg;
	logic scl_d_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			en_d_reg  <= 1'b0;
			cs_d_reg  <= 1'b1;
			ck_d_reg  <= 1'b1;
			sda_d_reg <= 1'b1;
			scl_d_reg <= 1'b1;
		end else begin
			en_d_reg  <= par.en;
			cs_d_reg  <= cs_n;
			ck_d_reg  <= spi_ck;
			sda_d_reg <= sda;
			scl_d_reg <= scl;
		end
	end

	logic en_fall;
	logic ck_rise;
	logic cs_fall;
	logic i2c_start;
	logic i2c_stop;
	logic scl_rise;
	logic scl_fall;

	assign en_fall   = en_d_reg && !par.en;
	assign ck_rise   = !ck_d_reg && spi_ck && !cs_n; // [R8] [R24]
	assign cs_fall   = cs_d_reg && !cs_n;
	assign scl_rise  = !scl_d_reg && scl;
	assign scl_fall  = scl_d_reg && !scl;
	assign i2c_start = scl && scl_d_reg && sda_d_reg && !sda; // [R10] [R11]
	assign i2c_stop  = scl && scl_d_reg && !sda_d_reg && sda; // [R10] [R11]

	// ==========================================================
	// Common byte delivery
	logic       busy;
	logic       par_put;
	logic       spi_put;
	logic       i2c_put;
	lhi_byte_s  par_byte;
	lhi_byte_s  spi_byte;
	lhi_byte_s  i2c_byte;
	lhi_byte_s  out_next;
	logic       put_any;
	logic       busy_start;

	always_comb begin
		out_next = par_byte;
		put_any  = 1'b0;
		unique case (port_reg)
			LHI_PORT_PAR: begin
				out_next = par_byte;
				put_any  = par_put;
			end
			LHI_PORT_SPI: begin
				out_next = spi_byte;
				put_any  = spi_put;
			end
			LHI_PORT_I2C: begin
				out_next = i2c_byte;
				put_any  = i2c_put;
			end
			default: begin
				put_any  = 1'b0;
			end
		endcase
	end

	assign busy_start = put_any && strap_done_reg;

	lhi_busy u_busy (
		.mclk_i   (mclk_i),
		.arst_n_i (arst_n_i),
		.start_i  (busy_start),
		.busy_o   (busy)
	);

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			byte_valid_o   <= 1'b0;
			byte_is_data_o <= 1'b0;
			byte_value_o   <= 8'h00;
		end else begin
			byte_valid_o <= busy_start;
			if (busy_start) begin
				byte_is_data_o <= out_next.is_data;
				byte_value_o   <= out_next.value;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_indicator_o <= 1'b0;
		end else begin
			busy_indicator_o <= busy || busy_start;
		end
	end

	// Data bytes advance the RAM pointer on every port
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ram_ptr_o <= 7'h00;
		end else if (busy_start && out_next.is_data) begin
			ram_ptr_o <= ram_ptr_o + 7'h01; // [R21]
		end
	end

	// ==========================================================
	// Parallel port
	logic       nib_second_reg;
	logic [3:0] nib_hi_reg;
	logic       par_write;

	assign par_write = (port_reg == LHI_PORT_PAR) && en_fall && !par.rw;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			nib_second_reg <= 1'b0;
			nib_hi_reg     <= 4'h0;
		end else if (!width_select_bit_i && en_fall) begin // [R22]
			nib_second_reg <= !nib_second_reg; // [R1]
			if (!nib_second_reg) begin
				nib_hi_reg <= par.db[7:4]; // [R2]
			end
		end else if (width_select_bit_i) begin
			nib_second_reg <= 1'b0;
		end
	end

	always_comb begin
		par_byte.is_data = par.rs;
		if (width_select_bit_i) begin
			par_byte.value = par.db; // [R4]
			par_put        = par_write;
		end else begin
			par_byte.value = {nib_hi_reg, par.db[7:4]}; // [R2]
			par_put        = par_write && nib_second_reg; // [R3]
		end
	end

	// Status and data read drive
	logic [7:0] rd_word;
	logic       rd_active;
	logic       rd_lo_nib;
	logic       i2c_ack_drv;

	assign rd_active = (port_reg == LHI_PORT_PAR) && par.en && par.rw;
	assign rd_lo_nib = !width_select_bit_i && nib_second_reg;
	assign rd_word   = par.rs ? byte_value_o : {busy_indicator_o, addr_counter_i}; // [R23]

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			db_o      <= 8'h00;
			db_oe_n_o <= 8'hff;
		end else if (port_reg == LHI_PORT_I2C) begin
			db_o      <= 8'h00;
			db_oe_n_o <= {1'b1, !i2c_ack_drv, 6'h3f}; // [R13] [R14] [R19]
		end else if (rd_active) begin
			db_o      <= rd_lo_nib ? {rd_word[3:0], 4'h0} : rd_word;
			db_oe_n_o <= width_select_bit_i ? 8'h00 : 8'h0f;
		end else begin
			db_o      <= 8'h00;
			db_oe_n_o <= 8'hff;
		end
	end

	// ==========================================================
	// SPI port
	logic [6:0] spi_sh_reg;
	logic [2:0] spi_cnt_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			spi_sh_reg  <= 7'h00;
			spi_cnt_reg <= 3'h0;
		end else if (cs_fall || cs_n) begin
			spi_cnt_reg <= 3'h0; // [R24]
		end else if (ck_rise) begin
			spi_sh_reg  <= {spi_sh_reg[5:0], spi_si}; // [R25]
			spi_cnt_reg <= spi_cnt_reg + 3'h1;
		end
	end

	assign spi_put  = (port_reg == LHI_PORT_SPI) && ck_rise && (spi_cnt_reg == 3'h7);
	assign spi_byte = '{is_data: par.rs, value: {spi_sh_reg, spi_si}}; // [R25]

	// ==========================================================
	// I2C slave, write only
	typedef enum logic [2:0] {
		I2C_IDLE = 3'b000,
		I2C_ADDR = 3'b001,
		I2C_CTRL = 3'b010,
		I2C_PAIR = 3'b011,
		I2C_DATA = 3'b100,
		I2C_SKIP = 3'b101
	} lhi_i2c_e;

	lhi_i2c_e   i2c_st_reg;
	logic [7:0] i2c_sh_reg;
	logic [3:0] i2c_bit_reg;
	logic       ctl_follow_reg;
	logic       ctl_ram_reg;
	logic       byte_done;
	logic [7:0] rx_byte;

	assign byte_done = scl_rise && (i2c_bit_reg == 4'h7);
	assign rx_byte   = {i2c_sh_reg[6:0], sda};

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			i2c_sh_reg  <= 8'h00;
			i2c_bit_reg <= 4'h0;
		end else if (i2c_start || i2c_stop) begin
			i2c_bit_reg <= 4'h0;
		end else if (scl_rise) begin
			i2c_sh_reg  <= rx_byte;
			i2c_bit_reg <= (i2c_bit_reg == 4'h8) ? 4'h0 : i2c_bit_reg + 4'h1;
		end
	end

	// Ack is held from the falling edge after bit 8 to the next falling edge
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			i2c_ack_drv <= 1'b0;
		end else if (i2c_start || i2c_stop || port_reg != LHI_PORT_I2C) begin
			i2c_ack_drv <= 1'b0;
		end else if (scl_fall) begin
			i2c_ack_drv <= (i2c_bit_reg == 4'h8) && (i2c_st_reg != I2C_IDLE)
				&& (i2c_st_reg != I2C_SKIP); // [R13] [R16]
		end
	end

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			i2c_st_reg     <= I2C_IDLE;
			ctl_follow_reg <= 1'b0;
			ctl_ram_reg    <= 1'b0;
		end else if (i2c_stop || port_reg != LHI_PORT_I2C) begin
			i2c_st_reg <= I2C_IDLE;
		end else if (i2c_start) begin
			i2c_st_reg <= I2C_ADDR;
		end else if (scl_fall && i2c_bit_reg == 4'h8 && !i2c_ack_drv) begin
			unique case (i2c_st_reg)
				I2C_IDLE: i2c_st_reg <= I2C_IDLE;
				I2C_ADDR: i2c_st_reg <= I2C_SKIP;
				I2C_CTRL: i2c_st_reg <= I2C_CTRL;
				I2C_PAIR: i2c_st_reg <= I2C_PAIR;
				I2C_DATA: i2c_st_reg <= I2C_DATA;
				I2C_SKIP: i2c_st_reg <= I2C_SKIP;
				default:  i2c_st_reg <= I2C_IDLE;
			endcase
		end else if (byte_done) begin
			unique case (i2c_st_reg)
				I2C_ADDR: begin
					// Read requests and foreign addresses are ignored
					if (rx_byte[7:1] == {LHI_I2C_ADDR_HI, addr_strap} && !rx_byte[0]) begin
						i2c_st_reg <= I2C_CTRL; // [R15] [R19]
					end else begin
						i2c_st_reg <= I2C_SKIP; // [R16]
					end
				end
				I2C_CTRL: begin
					ctl_follow_reg <= rx_byte[LHI_CTRL_FOLLOW];
					ctl_ram_reg    <= rx_byte[LHI_CTRL_RAM];
					i2c_st_reg     <= rx_byte[LHI_CTRL_FOLLOW] ? I2C_PAIR : I2C_DATA; // [R17]
				end
				I2C_PAIR: i2c_st_reg <= ctl_follow_reg ? I2C_CTRL : I2C_DATA;
				I2C_DATA: i2c_st_reg <= I2C_DATA; // [R17]
				I2C_IDLE: i2c_st_reg <= I2C_IDLE;
				I2C_SKIP: i2c_st_reg <= I2C_SKIP;
				default:  i2c_st_reg <= I2C_IDLE;
			endcase
		end
	end

	assign i2c_put  = byte_done && ((i2c_st_reg == I2C_PAIR) || (i2c_st_reg == I2C_DATA));
	assign i2c_byte = '{is_data: ctl_ram_reg, value: rx_byte}; // [R18] [R20]

endmodule // lhi_host_if

//--- hdl/lhi_pkg.sv
// Package for the display host interface unit: strap codes, I2C address,
// carrier structs and timing figures.
// Assumes a single 100 MHz core clock.
package lhi_pkg;

	// ==========================================================
	// Host port selection
	typedef enum logic [1:0] {
		LHI_PORT_PAR = 2'b00,
		LHI_PORT_I2C = 2'b01,
		LHI_PORT_SPI = 2'b10,
		LHI_PORT_BAD = 2'b11
	} lhi_port_e;

	// ==========================================================
	// I2C address, control byte and status fields
	localparam logic [4:0] LHI_I2C_ADDR_HI   = 5'h0f;
	localparam int         LHI_CTRL_FOLLOW   = 7;
	localparam int         LHI_CTRL_RAM      = 6;
	localparam int         LHI_BUSY_BIT      = 7;

	// ==========================================================
	// Timing
	localparam int         LHI_CLK_MHZ       = 100;
	localparam int         LHI_BUSY_NS       = 400;
	localparam int         LHI_BUSY_CYC      = (LHI_BUSY_NS * LHI_CLK_MHZ) / 1000;
	localparam logic [7:0] LHI_BUSY_CYC_W    = 8'(LHI_BUSY_CYC);

	// ==========================================================
	// Delivered byte
	typedef struct packed {
		logic       is_data;
		logic [7:0] value;
	} lhi_byte_s;

	// Parallel pins
	typedef struct packed {
		logic       en;
		logic       rs;
		logic       rw;
		logic [7:0] db;
	} lhi_par_s;

endpackage

//--- hdl/lhi_sync.sv
// Two-flop synchroniser bank for pins entering the core clock domain.
// Assumes inputs are asynchronous levels.
`timescale 1ns/1ps
module lhi_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_reg <= '0;
			sync_o   <= '0;
		end else begin
			meta_reg <= async_i;
			sync_o   <= meta_reg;
		end
	end
endmodule // lhi_sync

//--- hdl/lhi_busy.sv
// Busy timer: raised for a fixed count after each delivered byte.
// Assumes start_i is a one-cycle pulse on the core clock.
`timescale 1ns/1ps
module lhi_busy
	import lhi_pkg::*;
(
	input  wire logic mclk_i,
	input  wire logic arst_n_i,
	input  wire logic start_i,
	output logic      busy_o
);
	logic [7:0] cnt_reg;

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_reg <= 8'h00;
		end else if (start_i) begin
			cnt_reg <= LHI_BUSY_CYC_W;
		end else if (cnt_reg != 8'h00) begin
			cnt_reg <= cnt_reg - 8'h01;
		end
	end

	assign busy_o = (cnt_reg != 8'h00);
endmodule // lhi_busy

//--- testbench/lhi_host_if_sva.sv
// Port checks for the host interface unit.
// Assumes straps change only while reset is held.
`timescale 1ns/1ps
module lhi_host_if_sva (
	input  wire logic       mclk_i,
	input  wire logic       arst_n_i,
	input  wire logic       bus_select_strap_upper_i,
	input  wire logic       bus_select_strap_lower_i,
	input  wire logic [7:0] db_o,
	input  wire logic [7:0] db_oe_n_o,
	input  wire logic       byte_valid_o,
	input  wire logic       byte_is_data_o,
	input  wire logic [6:0] ram_ptr_o,
	input  wire logic       busy_indicator_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!arst_n_i);

	// ========
	// Delivery and busy
	a_valid_one_cycle: assert property (byte_valid_o |=> !byte_valid_o)
		else $error("byte_valid_o held over one cycle");
	a_busy_from_byte: assert property ($rose(busy_indicator_o) |->
		byte_valid_o || $past(byte_valid_o)) else $error("busy rose with no byte");
	a_busy_holds: assert property ($rose(busy_indicator_o) |-> busy_indicator_o[*8])
		else $error("busy dropped early");
	a_busy_ends: assert property ($rose(busy_indicator_o) |->
		##36 busy_indicator_o ##[1:6] !busy_indicator_o) else $error("busy length wrong");
	a_ptr_step: assert property (byte_valid_o && byte_is_data_o |=>
		ram_ptr_o == $past(ram_ptr_o, 2) + 7'h01) else $error("ram_ptr_o not advanced");
	a_ptr_hold: assert property ($changed(ram_ptr_o) |->
		byte_valid_o || $past(byte_valid_o)) else $error("ram_ptr_o moved alone");

	// ========
	// Pin drive
	a_ack_low: assert property (bus_select_strap_lower_i && !db_oe_n_o[6] |-> !db_o[6])
		else $error("acknowledge drives high");
	a_spi_silent: assert property (bus_select_strap_upper_i && !bus_select_strap_lower_i
		|-> db_oe_n_o == 8'hff) else $error("pins driven in serial port");
	a_i2c_sda_only: assert property (bus_select_strap_lower_i && !bus_select_strap_upper_i
		|-> (db_oe_n_o | 8'h40) == 8'hff) else $error("pin other than data line driven");

	c_data_byte: cover property (byte_valid_o && byte_is_data_o);
	c_busy: cover property ($rose(busy_indicator_o));
	c_ack: cover property (bus_select_strap_lower_i && !db_oe_n_o[6]);
endmodule // lhi_host_if_sva

bind lhi_host_if lhi_host_if_sva u_sva (
	.mclk_i, .arst_n_i, .bus_select_strap_upper_i, .bus_select_strap_lower_i,
	.db_o, .db_oe_n_o, .byte_valid_o, .byte_is_data_o, .ram_ptr_o, .busy_indicator_o
);

//--- testbench/lhi_mpu_model.sv
// Host processor model: parallel strobes, SPI and I2C master cycles.
// Assumes the bench resolves the open-drain data line into sda_i.
`timescale 1ns/1ps
module lhi_mpu_model (
	input  wire logic       mclk_i,
	input  wire logic       sda_i,
	input  wire logic [7:0] dout_i,
	input  wire logic [7:0] oe_n_i,
	output logic            en_o,
	output logic            rs_o,
	output logic            rw_o,
	output logic      [7:0] pins_o,
	output logic      [7:0] rd_o,
	output logic      [7:0] rdoe_o
);
	initial begin
		en_o = 1'b0;
		rs_o = 1'b0;
		rw_o = 1'b0;
		pins_o = 8'hff;
	end

	task automatic w(input int n);
		repeat (n) @(negedge mclk_i);
	endtask

	task automatic set_pins(input logic [7:0] v);
		pins_o = v;
	endtask

	// ========
	// Parallel: select, direction and data held across the falling strobe
	task automatic strobe(input logic rs, input logic rw, input logic [7:0] d, input int post);
		w(1);
		rs_o = rs;
		rw_o = rw;
		pins_o = rw ? ~pins_o : d;
		w(2);
		en_o = 1'b1;
		w(6);
		rd_o = dout_i;
		rdoe_o = oe_n_i;
		en_o = 1'b0;
		w(post);
		pins_o = ~pins_o;
	endtask

	// ========
	// SPI: clock idles high, data moves only while clock is low or select is high
	task automatic spi(input logic rs, input logic [7:0] d, input int n);
		rs_o = rs;
		pins_o[5] = 1'b0;
		w(4);
		for (int i = 7; i > 7 - n; i--) begin
			pins_o[6] = 1'b0;
			pins_o[7] = d[i];
			w(4);
			pins_o[6] = 1'b1;
			w(4);
		end
		pins_o[5] = 1'b1;
		pins_o[7] = ~pins_o[7];
		w(8);
	endtask

	// ========
	// I2C: conditions with clock high, data changed only with clock low
	task automatic i2c_cond(input logic start);
		pins_o[6] = start;
		w(2);
		pins_o[7] = 1'b1;
		w(4);
		pins_o[6] = ~start;
		w(4);
		if (start) begin
			pins_o[7] = 1'b0;
			w(4);
		end
	endtask

	task automatic i2c_byte(input logic [7:0] d, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			w(1);
			pins_o[6] = (i == 0) ? 1'b1 : d[i-1];
			w(3);
			pins_o[7] = 1'b1;
			w(2);
			if (i == 0) ack = !sda_i;
			w(2);
			pins_o[7] = 1'b0;
		end
	endtask
endmodule // lhi_mpu_model

//--- testbench/lhi_host_if_test.sv
// Self-checking bench for the host interface unit on all three ports.
// Assumes lhi_mpu_model as host and the bound port checker.
`timescale 1ns/1ps
module lhi_host_if_test;
	typedef struct packed {logic rs; logic [7:0] v;} lhi_row_s;
	lhi_row_s   rows [5] = '{'{1'b0, 8'h38}, '{1'b1, 8'h41}, '{1'b1, 8'hff},
	                         '{1'b0, 8'h01}, '{1'b1, 8'h00}};
	logic [7:0] i2c_seq [5] = '{8'h80, 8'h0c, 8'h40, 8'h41, 8'h42};
	logic       mclk_i, arst_n_i, upper, lower, width, en, rs, rw, valid, is_data, busy, ack;
	logic [6:0] ac, ptr, np;
	logic [7:0] pins, db_o, oe_n, value, rd, rdoe;
	wire  [7:0] db_i = {pins[7], pins[6] & (oe_n[6] | db_o[6]), pins[5:0]};
	int         miscompares, n_tests, n_valid, nv;

	lhi_mpu_model hst (.mclk_i(mclk_i), .sda_i(db_i[6]), .dout_i(db_o), .oe_n_i(oe_n),
		.en_o(en), .rs_o(rs), .rw_o(rw), .pins_o(pins), .rd_o(rd), .rdoe_o(rdoe));

	lhi_host_if dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus_select_strap_upper_i(upper),
		.bus_select_strap_lower_i(lower), .width_select_bit_i(width), .par_en_i(en),
		.reg_select_line_i(rs), .par_rw_i(rw), .db_i(db_i), .addr_counter_i(ac),
		.db_o(db_o), .db_oe_n_o(oe_n), .byte_valid_o(valid), .byte_is_data_o(is_data),
		.byte_value_o(value), .ram_ptr_o(ptr), .busy_indicator_o(busy));

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	always @(posedge mclk_i) if (valid === 1'b1) n_valid++;

	// ========
	// Checking helpers
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_bit(input string nm, input logic e, input logic g);
		chk_byte(nm, {7'h00, e}, {7'h00, g});
	endtask

	task automatic exp_byte(input logic d, input logic [7:0] v, input logic [6:0] p);
		chk_byte("byte_count", 8'(nv), 8'(n_valid));
		chk_bit("byte_is_data_o", d, is_data);
		chk_byte("byte_value_o", v, value);
		chk_byte("ram_ptr_o", {1'b0, p}, {1'b0, ptr});
	endtask

	task automatic report_and_stop;
		$display("TB: %0d comparisons, %0d mismatches", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Busy is the only handshake; a stuck flag ends the run
	task automatic wait_idle;
		int k;
		for (k = 0; k < 100 && busy !== 1'b0; k++) @(negedge mclk_i);
		if (k == 100) begin
			miscompares++;
			report_and_stop();
		end
	endtask

	task automatic do_reset(input logic u, input logic l, input logic wd, input logic [7:0] p);
		arst_n_i = 1'b0;
		upper = u;
		lower = l;
		width = wd;
		hst.set_pins(p);
		repeat (3) @(negedge mclk_i);
		arst_n_i = 1'b1;
		repeat (6) @(negedge mclk_i);
	endtask

	// ========
	// Main sequence
	initial begin
		arst_n_i = 1'b0;
		ac = 7'h2a;
		{upper, lower, width} = 3'b001;
		do_reset(1'b0, 1'b0, 1'b1, 8'hff);
		chk_byte("db_oe_n_o", 8'hff, oe_n);
		np = 7'h00;
		for (int i = 0; i < 5; i++) begin
			hst.strobe(rows[i].rs, 1'b0, rows[i].v, 4);
			wait_idle();
			nv++;
			np += 7'(rows[i].rs);
			exp_byte(rows[i].rs, rows[i].v, np);
		end
		hst.strobe(1'b0, 1'b0, 8'h80, 2);
		hst.strobe(1'b0, 1'b1, 8'h00, 2);
		nv++;
		chk_byte("status_busy", {1'b1, ac}, rd);
		chk_byte("read_oe_n", 8'h00, rdoe);
		wait_idle();
		hst.strobe(1'b0, 1'b1, 8'h00, 2);
		chk_byte("status_idle", {1'b0, ac}, rd);
		// Narrow port: low lines carry noise that must be ignored
		do_reset(1'b0, 1'b0, 1'b0, 8'hff);
		chk_byte("reset_ram_ptr_o", 8'h00, {1'b0, ptr});
		hst.strobe(1'b1, 1'b0, 8'ha3, 8);
		chk_bit("busy_first_nibble", 1'b0, busy);
		chk_byte("byte_count", 8'(nv), 8'(n_valid));
		hst.strobe(1'b1, 1'b0, 8'h5c, 8);
		chk_bit("busy_second_nibble", 1'b1, busy);
		nv++;
		exp_byte(1'b1, 8'ha5, 7'h01);
		wait_idle();
		// SPI with an aborted partial byte
		do_reset(1'b1, 1'b0, 1'b1, 8'hff);
		hst.spi(1'b1, 8'hc3, 8);
		wait_idle();
		nv++;
		exp_byte(1'b1, 8'hc3, 7'h01);
		hst.spi(1'b1, 8'hff, 3);
		hst.spi(1'b0, 8'h5a, 8);
		wait_idle();
		nv++;
		exp_byte(1'b0, 8'h5a, 7'h01);
		// I2C, chip select tied low, address straps 2'b10
		do_reset(1'b0, 1'b1, 1'b1, 8'hc2);
		hst.i2c_cond(1'b1);
		hst.i2c_byte(8'h7c, ack);
		chk_bit("addr_ack", 1'b1, ack);
		for (int i = 0; i < 5; i++) begin
			hst.i2c_byte(i2c_seq[i], ack);
			chk_bit("byte_ack", 1'b1, ack);
			if (i == 1) begin
				nv++;
				exp_byte(1'b0, 8'h0c, 7'h00);
			end
		end
		hst.i2c_cond(1'b0);
		nv += 2;
		exp_byte(1'b1, 8'h42, 7'h02);
		foreach (i2c_seq[i]) begin
			if (i == 0) hst.i2c_cond(1'b1);
			hst.i2c_byte(i == 0 ? 8'h7a : (i == 3 ? 8'h7d : 8'h55), ack);
			chk_bit("foreign_ack", 1'b0, ack);
			if (i == 2) hst.i2c_cond(1'b1);
		end
		hst.i2c_cond(1'b0);
		chk_byte("byte_count", 8'(nv), 8'(n_valid));
		report_and_stop();
	end
endmodule // lhi_host_if_test
